// *** logic/qrvsc_pkg.sv ***
`default_nettype none
package qrvsc_pkg;

   // ****************************************
   // clock and derived timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS    = 25;
   localparam int unsigned EVAL_PERIOD_MS   = 48;
   localparam int unsigned SOFT_START_MS    = 12;
   localparam int unsigned SOFT_START_STEPS = 4;
   localparam int unsigned LEB_NS           = 250;
   localparam int unsigned MAX_ON_NS        = 30000;
   localparam int unsigned MAX_OFF_NS       = 50000;
   localparam int unsigned RING_LONG_NS     = 2500;
   localparam int unsigned RING_SHORT_NS    = 1000;
   localparam int unsigned OVP_BLANK_NS     = 3000;

   // least times round up, longest times round down
   localparam int unsigned EVAL_CYCLES     = EVAL_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned SS_STEP_CYCLES  = SOFT_START_MS * 1000000 / SOFT_START_STEPS / CLK_PERIOD_NS;
   localparam int unsigned LEB_CYCLES      = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MAX_ON_CYCLES   = MAX_ON_NS / CLK_PERIOD_NS;
   localparam int unsigned MAX_OFF_CYCLES  = MAX_OFF_NS / CLK_PERIOD_NS;
   localparam int unsigned RING_LONG_CYC   = (RING_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RING_SHORT_CYC  = (RING_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OVP_BLANK_CYC   = (OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************
   // counter limits and reset values
   // ****************************************
   localparam logic [2:0] VALLEY_MIN   = 3'h1;
   localparam logic [2:0] VALLEY_MAX   = 3'h7;
   localparam logic [2:0] VALLEY_RESET = 3'h1;
   localparam logic [2:0] ZC_MAX       = 3'h7;
   localparam logic [2:0] ZC_RESET     = 3'h0;

   // ****************************************
   // soft-start peak limit, millivolts
   // ****************************************
   localparam logic [9:0] PEAK_STEP0_MV = 10'h140;
   localparam logic [9:0] PEAK_STEP1_MV = 10'h223;
   localparam logic [9:0] PEAK_STEP2_MV = 10'h305;
   localparam logic [9:0] PEAK_FINAL_MV = 10'h3E8;

   // ****************************************
   // comparator inputs from the power stage
   // ****************************************
   typedef struct packed {
      logic supplyGood;
      logic fbAboveLow;
      logic fbAboveHigh;
      logic fbAboveReset;
      logic zcAboveZero;
      logic zcAboveOvp;
      logic zcAboveRing;
      logic csTrip;
      logic lineHigh;
   } qrvsc_cmp_t;

   localparam int unsigned CMP_W = $bits(qrvsc_cmp_t);

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_ON    = 5'h02,
      ST_RING  = 5'h04,
      ST_WAIT  = 5'h08,
      ST_LATCH = 5'h10
   } qrvsc_state_t;

endpackage : qrvsc_pkg
`default_nettype wire

// *** logic/qrvsc_ctrl.sv ***
// What this block does
// R1: supply good: startup cell off, soft-start begins
// R2: soft-start 12ms, four steps, 0.32V to 1V
// R3: turn-on from counters, turn-off from comparator
// R4: valley counter holds turn-on zero-crossing index
// R5: valley counter updated once per 48ms period
// R6: feedback always below low: increment, stop 7
// R7: above low, never above high: hold
// R8: above high, never above reset: decrement, stop 1
// R9: above reset threshold: force valley counter 1
// R10: valley counter confined to 1..7
// R11: valley counter starts at 1
// R12: feedback thresholds selected by line level
// R13: zero-crossing counter holds 0..7 only
// R14: count falling 100mV crossings while switch off
// R15: clear zero-crossing counter on gate turn-on
// R16: overvoltage while off latches off after blanking
// R17: gate held low through ringing suppression
// R18: after suppression, on when zc >= valley
// R19: maximum off time forces turn-on
// R20: sticky threshold flags per period, then cleared
// R21: zero-crossing counter saturates at 7
`timescale 1ns/1ps
`default_nettype none
module qrvsc_ctrl #(
   parameter int unsigned EVAL_CYC = qrvsc_pkg::EVAL_CYCLES,
   parameter int unsigned SS_CYC   = qrvsc_pkg::SS_STEP_CYCLES
) (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   // analog comparators, asynchronous
   input  wire qrvsc_pkg::qrvsc_cmp_t cmpIn,
   // gate and supply control
   output logic                       gateDrive,
   output logic                       startupCellOff,
   output logic [9:0]                 peakLimitMv,
   output logic                       softStartDone,
   output logic                       fbThrSelHigh,
   // status
   output logic                       latchedOff,
   output logic [2:0]                 valleyCount,
   output logic [2:0]                 zcCount
);

   // ****************************************
   // reset release and input synchronisers
   // ****************************************
   logic                        rstMeta_reg;
   logic                        rstSyncN;
   logic [qrvsc_pkg::CMP_W-1:0] cmpMeta_reg;
   logic [qrvsc_pkg::CMP_W-1:0] cmpSync_reg;
   qrvsc_pkg::qrvsc_cmp_t       cmp;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rstMeta_reg <= 1'b0;
         rstSyncN    <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSyncN    <= rstMeta_reg;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < qrvsc_pkg::CMP_W; gi++) begin : g_sync
         always_ff @(posedge clk_sys or negedge rstSyncN) begin
            if (!rstSyncN) begin
               cmpMeta_reg[gi] <= 1'b0;
               cmpSync_reg[gi] <= 1'b0;
            end else begin
               cmpMeta_reg[gi] <= cmpIn[gi];
               cmpSync_reg[gi] <= cmpMeta_reg[gi];
            end
         end
      end
   endgenerate

   assign cmp = qrvsc_pkg::qrvsc_cmp_t'(cmpSync_reg);

   // ****************************************
   // soft-start sequencer
   // ****************************************
   logic        startupOff_reg, startupOff_next;
   logic [1:0]  ssStep_reg, ssStep_next;
   logic [16:0] ssTimer_reg, ssTimer_next;
   logic        ssDone_reg, ssDone_next;
   logic [9:0]  peak_reg, peak_next;
   logic        thrSel_reg, thrSel_next;

   always_comb begin
      startupOff_next = startupOff_reg;
      ssStep_next     = ssStep_reg;
      ssTimer_next    = ssTimer_reg;
      ssDone_next     = ssDone_reg;
      // R1: supply good
      if (cmp.supplyGood) begin
         startupOff_next = 1'b1;
      end
      // R2: timed steps
      if (startupOff_reg && !ssDone_reg) begin
         if (ssTimer_reg == 17'(SS_CYC - 1)) begin
            ssTimer_next = 17'h00000;
            if (ssStep_reg == 2'h3) begin
               ssDone_next = 1'b1;
            end else begin
               ssStep_next = ssStep_reg + 2'h1;
            end
         end else begin
            ssTimer_next = ssTimer_reg + 17'h00001;
         end
      end
      unique case (ssStep_next)
         2'h0: peak_next = qrvsc_pkg::PEAK_STEP0_MV;
         2'h1: peak_next = qrvsc_pkg::PEAK_STEP1_MV;
         2'h2: peak_next = qrvsc_pkg::PEAK_STEP2_MV;
         2'h3: peak_next = qrvsc_pkg::PEAK_FINAL_MV;
      endcase
      // R12: thresholds follow line level
      thrSel_next = cmp.lineHigh;
   end

   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         startupOff_reg <= 1'b0;
         ssStep_reg     <= 2'h0;
         ssTimer_reg    <= 17'h00000;
         ssDone_reg     <= 1'b0;
         peak_reg       <= qrvsc_pkg::PEAK_STEP0_MV;
         thrSel_reg     <= 1'b0;
      end else begin
         startupOff_reg <= startupOff_next;
         ssStep_reg     <= ssStep_next;
         ssTimer_reg    <= ssTimer_next;
         ssDone_reg     <= ssDone_next;
         peak_reg       <= peak_next;
         thrSel_reg     <= thrSel_next;
      end
   end

   // ****************************************
   // gate state machine and timers
   // ****************************************
   qrvsc_pkg::qrvsc_state_t state_reg, state_next;
   logic        gate_reg, gate_next;
   logic [11:0] onTimer_reg, onTimer_next;
   logic [11:0] offTimer_reg, offTimer_next;
   logic [7:0]  ringTimer_reg, ringTimer_next;
   logic        ringLong_reg, ringLong_next;
   logic [7:0]  ovpTimer_reg, ovpTimer_next;
   logic [2:0]  zc_reg;
   logic [2:0]  valley_reg;
   logic        turnOn;
   logic        offState;

   assign offState = (state_reg == qrvsc_pkg::ST_RING) || (state_reg == qrvsc_pkg::ST_WAIT);

   always_comb begin
      state_next     = state_reg;
      onTimer_next   = onTimer_reg;
      offTimer_next  = offTimer_reg;
      ringTimer_next = ringTimer_reg;
      ringLong_next  = ringLong_reg;
      ovpTimer_next  = 8'h00;
      unique case (state_reg)
         qrvsc_pkg::ST_IDLE: begin
            if (cmp.supplyGood) begin
               state_next   = qrvsc_pkg::ST_ON;
               onTimer_next = 12'h000;
            end
         end
         qrvsc_pkg::ST_ON: begin
            onTimer_next = onTimer_reg + 12'h001;
            // R3: analog turn-off after blanking
            if ((onTimer_reg >= 12'(qrvsc_pkg::LEB_CYCLES - 1) && cmp.csTrip) ||
                onTimer_reg == 12'(qrvsc_pkg::MAX_ON_CYCLES - 1)) begin
               state_next     = qrvsc_pkg::ST_RING;
               offTimer_next  = 12'h000;
               ringTimer_next = 8'h00;
               ringLong_next  = !cmp.zcAboveRing;
            end
         end
         qrvsc_pkg::ST_RING, qrvsc_pkg::ST_WAIT: begin
            offTimer_next  = offTimer_reg + 12'h001;
            ringTimer_next = ringTimer_reg + 8'h01;
            // R17: hold low during suppression
            if (state_reg == qrvsc_pkg::ST_RING &&
                ringTimer_reg == (ringLong_reg ? 8'(qrvsc_pkg::RING_LONG_CYC - 1)
                                               : 8'(qrvsc_pkg::RING_SHORT_CYC - 1))) begin
               state_next = qrvsc_pkg::ST_WAIT;
            end
            // R18: valley reached
            if (state_reg == qrvsc_pkg::ST_WAIT && zc_reg >= valley_reg) begin
               state_next = qrvsc_pkg::ST_ON;
            end
            // R19: maximum off time
            if (offTimer_reg == 12'(qrvsc_pkg::MAX_OFF_CYCLES - 1)) begin
               state_next = qrvsc_pkg::ST_ON;
            end
            if (state_next == qrvsc_pkg::ST_ON) begin
               onTimer_next = 12'h000;
            end
            // R16: sustained overvoltage latches off
            if (cmp.zcAboveOvp) begin
               ovpTimer_next = ovpTimer_reg + 8'h01;
               if (ovpTimer_reg == 8'(qrvsc_pkg::OVP_BLANK_CYC - 1)) begin
                  state_next = qrvsc_pkg::ST_LATCH;
               end
            end
         end
         qrvsc_pkg::ST_LATCH: begin
            state_next = qrvsc_pkg::ST_LATCH;
         end
         default: begin
            state_next = qrvsc_pkg::ST_LATCH;
         end
      endcase
      gate_next = (state_next == qrvsc_pkg::ST_ON);
   end

   assign turnOn = gate_next && !gate_reg;

   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state_reg     <= qrvsc_pkg::ST_IDLE;
         gate_reg      <= 1'b0;
         onTimer_reg   <= 12'h000;
         offTimer_reg  <= 12'h000;
         ringTimer_reg <= 8'h00;
         ringLong_reg  <= 1'b1;
         ovpTimer_reg  <= 8'h00;
      end else begin
         state_reg     <= state_next;
         gate_reg      <= gate_next;
         onTimer_reg   <= onTimer_next;
         offTimer_reg  <= offTimer_next;
         ringTimer_reg <= ringTimer_next;
         ringLong_reg  <= ringLong_next;
         ovpTimer_reg  <= ovpTimer_next;
      end
   end

   // ****************************************
   // zero-crossing counter
   // ****************************************
   logic       zcPrev_reg, zcPrev_next;
   logic [2:0] zc_next;

   always_comb begin
      zcPrev_next = cmp.zcAboveZero;
      zc_next     = zc_reg;
      // R15: clear on turn-on
      if (turnOn) begin
         zc_next = qrvsc_pkg::ZC_RESET;
      // R14: falling crossing while off
      end else if (!gate_reg && offState && zcPrev_reg && !cmp.zcAboveZero) begin
         // R21: saturate
         if (zc_reg != qrvsc_pkg::ZC_MAX) begin
            zc_next = zc_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         zcPrev_reg <= 1'b0;
         zc_reg     <= qrvsc_pkg::ZC_RESET;
      end else begin
         zcPrev_reg <= zcPrev_next;
         zc_reg     <= zc_next;
      end
   end

   // ****************************************
   // valley select counter
   // ****************************************
   logic [20:0] evalTimer_reg, evalTimer_next;
   logic        seenLow_reg, seenLow_next;
   logic        seenHigh_reg, seenHigh_next;
   logic        seenReset_reg, seenReset_next;
   logic [2:0]  valley_next;
   logic        evalTick;
   logic        running;

   assign running  = (state_reg != qrvsc_pkg::ST_IDLE) && (state_reg != qrvsc_pkg::ST_LATCH);
   assign evalTick = running && (evalTimer_reg == 21'(EVAL_CYC - 1));

   always_comb begin
      valley_next    = valley_reg;
      evalTimer_next = evalTimer_reg;
      if (running) begin
         evalTimer_next = evalTick ? 21'h000000 : evalTimer_reg + 21'h000001;
      end
      // R20: sticky flags; boundary sample starts next period
      seenLow_next   = (evalTick ? 1'b0 : seenLow_reg) | cmp.fbAboveLow;
      seenHigh_next  = (evalTick ? 1'b0 : seenHigh_reg) | cmp.fbAboveHigh;
      seenReset_next = (evalTick ? 1'b0 : seenReset_reg) | cmp.fbAboveReset;
      // R5: once per period
      if (evalTick) begin
         if (seenReset_reg) begin
            // R9: force to one
            valley_next = qrvsc_pkg::VALLEY_RESET;
         end else if (seenHigh_reg) begin
            // R8: decrement, R10: bounded
            if (valley_reg != qrvsc_pkg::VALLEY_MIN) begin
               valley_next = valley_reg - 3'h1;
            end
         end else if (!seenLow_reg) begin
            // R6: increment, R10: bounded
            if (valley_reg != qrvsc_pkg::VALLEY_MAX) begin
               valley_next = valley_reg + 3'h1;
            end
         end
         // R7: otherwise hold
      end
   end

   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         evalTimer_reg <= 21'h000000;
         seenLow_reg   <= 1'b0;
         seenHigh_reg  <= 1'b0;
         seenReset_reg <= 1'b0;
         // R11: start at one
         valley_reg    <= qrvsc_pkg::VALLEY_RESET;
      end else begin
         evalTimer_reg <= evalTimer_next;
         seenLow_reg   <= seenLow_next;
         seenHigh_reg  <= seenHigh_next;
         seenReset_reg <= seenReset_next;
         valley_reg    <= valley_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic latched_reg;

   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         latched_reg <= 1'b0;
      end else begin
         latched_reg <= (state_next == qrvsc_pkg::ST_LATCH);
      end
   end

   // R4: valley index exposed; R13: zc range
   assign gateDrive      = gate_reg;
   assign startupCellOff = startupOff_reg;
   assign peakLimitMv    = peak_reg;
   assign softStartDone  = ssDone_reg;
   assign fbThrSelHigh   = thrSel_reg;
   assign latchedOff     = latched_reg;
   assign valleyCount    = valley_reg;
   assign zcCount        = zc_reg;

endmodule : qrvsc_ctrl
`default_nettype wire

// *** tb/qrvsc_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module qrvsc_ctrl_properties #(
   parameter int unsigned EVAL_CYC = 200,
   parameter int unsigned SS_CYC   = 50
) (
   // clock and reset
   input wire logic                  clk_sys,
   input wire logic                  resetn,
   // comparators
   input wire qrvsc_pkg::qrvsc_cmp_t cmpIn,
   // controller outputs
   input wire logic                  gateDrive,
   input wire logic                  startupCellOff,
   input wire logic [9:0]            peakLimitMv,
   input wire logic                  softStartDone,
   input wire logic                  fbThrSelHigh,
   input wire logic                  latchedOff,
   input wire logic [2:0]            valleyCount,
   input wire logic [2:0]            zcCount
);
   int         offCnt_reg;
   int         sinceChg_reg;
   logic [2:0] prevValley_reg;
   logic       firstDone_reg;

   // off time, spacing of valley changes, first turn-off seen
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         offCnt_reg     <= 0;
         sinceChg_reg   <= 0;
         prevValley_reg <= 3'h1;
         firstDone_reg  <= 1'b0;
      end else begin
         offCnt_reg     <= gateDrive ? 0 : (offCnt_reg < 4095 ? offCnt_reg + 1 : offCnt_reg);
         sinceChg_reg   <= (valleyCount != prevValley_reg) ? 0 : sinceChg_reg + 1;
         prevValley_reg <= valleyCount;
         firstDone_reg  <= firstDone_reg | $fell(gateDrive);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_idle_before_start: assert property (!startupCellOff |-> !gateDrive)
      else $error("gate switched before startup cell off");
   a_soft_start_final: assert property (softStartDone |-> peakLimitMv == 10'h3E8)
      else $error("peak limit not final after soft-start");
   a_valley_period_gap: assert property (valleyCount != prevValley_reg |-> sinceChg_reg >= EVAL_CYC - 2)
      else $error("valley count changed inside a period");
   a_valley_step_size: assert property (valleyCount != prevValley_reg |-> valleyCount == prevValley_reg + 3'h1
      || valleyCount == prevValley_reg - 3'h1 || valleyCount == 3'h1)
      else $error("valley count jumped");
   a_valley_in_range: assert property (valleyCount != 3'h0)
      else $error("valley count left range");
   a_line_select: assert property (cmpIn.lineHigh [*8] |-> fbThrSelHigh)
      else $error("threshold set ignores line level");
   a_zc_clear_on: assert property ($rose(gateDrive) |-> zcCount == 3'h0)
      else $error("zero-cross count not cleared at turn-on");
   a_zc_saturate: assert property (!gateDrive && $past(zcCount) == 3'h7 |-> zcCount == 3'h7)
      else $error("zero-cross count wrapped");
   a_latch_holds: assert property (latchedOff |=> latchedOff && !gateDrive)
      else $error("latch-off released");
   a_ring_hold_low: assert property ($rose(gateDrive) && firstDone_reg |-> offCnt_reg >= 40)
      else $error("turn-on inside ringing suppression");
   a_switch_on_cause: assert property ($rose(gateDrive) && firstDone_reg
      |-> $past(zcCount) >= $past(valleyCount) || offCnt_reg >= 1990)
      else $error("turn-on without cause");
   a_max_off_bound: assert property (firstDone_reg && !latchedOff |-> offCnt_reg <= 2005)
      else $error("off time above maximum");
endmodule : qrvsc_ctrl_properties

bind qrvsc_ctrl qrvsc_ctrl_properties #(.EVAL_CYC(EVAL_CYC), .SS_CYC(SS_CYC)) i_qrvsc_ctrl_properties (
   .clk_sys, .resetn, .cmpIn, .gateDrive, .startupCellOff, .peakLimitMv,
   .softStartDone, .fbThrSelHigh, .latchedOff, .valleyCount, .zcCount);
`default_nettype wire

// *** tb/qrvsc_stage_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module qrvsc_stage_model (
   // clock and gate
   input  wire logic                  clk_sys,
   input  wire logic                  gateDrive,
   // scenario settings
   input  wire logic                  supplyGood,
   input  wire logic [1:0]            fbLevel,
   input  wire logic                  lineHigh,
   input  wire logic                  overVolt,
   input  wire logic [3:0]            nValleys,
   // comparator results
   output var  qrvsc_pkg::qrvsc_cmp_t cmpIn
);
   int onCnt = 0;
   int offCnt = 0;

   initial cmpIn = '0;

   always @(posedge clk_sys) begin
      onCnt              <= gateDrive ? onCnt + 1 : 0;
      offCnt             <= gateDrive ? 0 : offCnt + 1;
      cmpIn.supplyGood   <= supplyGood;
      cmpIn.fbAboveLow   <= fbLevel >= 2'h1;
      cmpIn.fbAboveHigh  <= fbLevel >= 2'h2;
      cmpIn.fbAboveReset <= fbLevel == 2'h3;
      // ringing of period 16 dying after nValleys falls; period 8 from nValleys 8 up
      cmpIn.zcAboveZero  <= !gateDrive && offCnt < 16 * nValleys + 8 && offCnt[nValleys[3] ? 2 : 3];
      cmpIn.zcAboveOvp   <= !gateDrive && overVolt;
      // a single valley asks for the short suppression time
      cmpIn.zcAboveRing  <= nValleys == 4'h1;
      cmpIn.csTrip       <= gateDrive && onCnt >= 20;
      cmpIn.lineHigh     <= lineHigh;
   end
endmodule : qrvsc_stage_model
`default_nettype wire

// *** tb/qrvsc_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module qrvsc_ctrl_bench;
   localparam int unsigned EVAL = 200;
   localparam int unsigned SS   = 50;

   logic                  clk_sys = 1'b0;
   logic                  resetn = 1'b0;
   logic                  supplyGood = 1'b0;
   logic [1:0]            fbLevel = 2'h0;
   logic                  lineHigh = 1'b0;
   logic                  overVolt = 1'b0;
   logic [3:0]            nValleys = 4'h3;
   qrvsc_pkg::qrvsc_cmp_t cmpIn;
   logic                  gateDrive;
   logic                  startupCellOff;
   logic [9:0]            peakLimitMv;
   logic                  softStartDone;
   logic                  fbThrSelHigh;
   logic                  latchedOff;
   logic [2:0]            valleyCount;
   logic [2:0]            zcCount;
   logic [2:0]            lastZc;
   int                    mismatches = 0;
   int                    n_tests = 0;
   int                    i;

   always #12.5 clk_sys = ~clk_sys;

   qrvsc_ctrl #(.EVAL_CYC(EVAL), .SS_CYC(SS)) i_qrvsc_ctrl (.clk_sys, .resetn, .cmpIn, .gateDrive,
      .startupCellOff, .peakLimitMv, .softStartDone, .fbThrSelHigh, .latchedOff, .valleyCount, .zcCount);
   qrvsc_stage_model i_qrvsc_stage_model (.clk_sys, .gateDrive, .supplyGood, .fbLevel, .lineHigh,
      .overVolt, .nValleys, .cmpIn);

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("mismatches %0d, checks %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic give_up(input int n, input int lim);
      if (n >= lim) begin
         mismatches++;
         test_done();
      end
   endtask : give_up

   task automatic wait_gate(input logic lvl);
      for (i = 0; i < 3000 && gateDrive !== lvl; i++) @(negedge clk_sys);
      give_up(i, 3000);
   endtask : wait_gate

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(negedge clk_sys);
      check(valleyCount, 32'h1);
      check(zcCount, 32'h0);
      check(peakLimitMv, 32'h140);
   endtask : t_reset

   task automatic t_start;
      @(posedge clk_sys);
      supplyGood <= 1'b1;
      for (i = 0; i < 20 && startupCellOff !== 1'b1; i++) @(negedge clk_sys);
      check(startupCellOff, 32'h1);
      for (i = 0; i < SS + 20 && peakLimitMv === 10'h140; i++) @(negedge clk_sys);
      check(peakLimitMv, 32'h223);
      check(softStartDone, 32'h0);
      for (i = 0; i < 4 * SS && softStartDone !== 1'b1; i++) @(negedge clk_sys);
      give_up(i, 4 * SS);
      check(peakLimitMv, 32'h3E8);
   endtask : t_start

   task automatic t_line;
      @(posedge clk_sys);
      lineHigh <= 1'b1;
      repeat (8) @(negedge clk_sys);
      check(fbThrSelHigh, 32'h1);
      @(posedge clk_sys);
      lineHigh <= 1'b0;
      repeat (8) @(negedge clk_sys);
      check(fbThrSelHigh, 32'h0);
   endtask : t_line

   task automatic t_valley(input logic [1:0] lvl, input logic [2:0] exp, input int lim);
      @(posedge clk_sys);
      fbLevel <= lvl;
      for (i = 0; i < lim && valleyCount !== exp; i++) @(negedge clk_sys);
      if (lim == 0) begin
         repeat (2 * EVAL) @(negedge clk_sys);
      end
      check(valleyCount, exp);
   endtask : t_valley

   task automatic t_zc(input logic [3:0] n, input logic [2:0] expZc, input int expOff);
      @(posedge clk_sys);
      nValleys <= n;
      // a whole on time passes so the new ringing is settled at turn-off
      wait_gate(1'b0);
      wait_gate(1'b1);
      wait_gate(1'b0);
      for (i = 0; i < 3000 && gateDrive !== 1'b1; i++) begin
         lastZc = zcCount;
         @(negedge clk_sys);
      end
      check(lastZc, expZc);
      check(i, expOff);
      check(zcCount, 32'h0);
   endtask : t_zc

   task automatic t_rerun;
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(negedge clk_sys);
      check(latchedOff, 32'h0);
      check(valleyCount, 32'h1);
      check(startupCellOff, 32'h0);
   endtask : t_rerun

   task automatic t_maxoff;
      @(posedge clk_sys);
      nValleys <= 4'h0;
      wait_gate(1'b1);
      wait_gate(1'b0);
      for (i = 0; i < 3000 && gateDrive !== 1'b1; i++) @(negedge clk_sys);
      check(i >= 1990 && i <= 2010, 32'h1);
   endtask : t_maxoff

   task automatic t_ovp;
      wait_gate(1'b0);
      @(posedge clk_sys);
      overVolt <= 1'b1;
      for (i = 0; i < 400 && latchedOff !== 1'b1; i++) @(negedge clk_sys);
      check(latchedOff, 32'h1);
      repeat (2500) @(negedge clk_sys);
      check(gateDrive, 32'h0);
   endtask : t_ovp

   initial begin
      t_reset();
      t_start();
      t_line();
      t_valley(2'h0, 3'h7, 10 * EVAL);
      t_valley(2'h2, 3'h1, 10 * EVAL);
      t_valley(2'h0, 3'h4, 10 * EVAL);
      t_valley(2'h1, 3'h4, 0);
      t_valley(2'h3, 3'h1, 2 * EVAL + 20);
      t_zc(4'h5, 3'h5, qrvsc_pkg::RING_LONG_CYC + 1);
      t_zc(4'h9, 3'h7, qrvsc_pkg::RING_LONG_CYC + 1);
      t_zc(4'h1, 3'h1, qrvsc_pkg::RING_SHORT_CYC + 1);
      t_maxoff();
      t_ovp();
      t_rerun();
      test_done();
   end
endmodule : qrvsc_ctrl_bench
`default_nettype wire
